// ==== wdcf_defines.svh ====
`ifndef WDCF_DEFINES_SVH
`define WDCF_DEFINES_SVH
`define WDCF_ADDR_CAUSE    32'h00000000
`define WDCF_ADDR_CTRL     32'h00000004
`define WDCF_UNLOCK_BIT    4
`define WDCF_ON_BIT        3
`define WDCF_SEL_MSB       2
`define WDCF_SEL_LSB       0
`define WDCF_POR_BIT       0
`define WDCF_WDOG_FLAG_BIT 3
`define WDCF_BOR_FLAG_BIT  2
`define WDCF_PIN_FLAG_BIT  1
`define WDCF_UNLOCK_CYCLES 3'h4
`define WDCF_CNT_W         22
`define WDCF_BASE_TIMEOUT  16384
`define WDCF_CTRL_RST      5'h00
`define WDCF_CAUSE_RST     4'h1
`endif

// ==== wdcf_pkg.sv ====
package wdcf_pkg;
  typedef struct packed {
    logic       watchdog_change_unlock;
    logic       watchdog_on_bit;
    logic [2:0] timeout_select;
  } wdcf_ctrl_t;

  typedef struct packed {
    logic watchdog_cause_flag;
    logic brownout_cause_flag;
    logic pin_reset_cause_flag;
    logic poweron_cause_flag;
  } wdcf_cause_t;

  typedef enum logic [1:0] {
    WDCF_REG_NONE,
    WDCF_REG_CAUSE,
    WDCF_REG_CTRL
  } wdcf_reg_t;
endpackage

// ==== wdcf_watchdog.sv ====
`timescale 1ns/1ps
`include "wdcf_defines.svh"
module wdcf_watchdog #(
  parameter int unsigned BASE_TIMEOUT = `WDCF_BASE_TIMEOUT
) (
  input  wire logic        clock,             // system clock, 100 MHz
  input  wire logic        nrst,              // power-on reset, async
  input  wire logic        clk_en,            // freezes all state when low
  input  wire logic        hsel,              // ahb select
  input  wire logic [31:0] haddr,             // ahb address
  input  wire logic [1:0]  htrans,            // ahb transfer type
  input  wire logic        hwrite,            // ahb write
  input  wire logic [2:0]  hsize,             // ahb size
  input  wire logic [31:0] hwdata,            // ahb write data
  input  wire logic        hready,            // ahb bus ready
  output logic             hreadyout,         // ahb slave ready
  output logic             hresp,             // ahb response
  output logic [31:0]      hrdata,            // ahb read data
  input  wire logic        wdt_osc,           // watchdog oscillator pin
  input  wire logic        safety_level_fuse, // fuse strap, high locks on
  input  wire logic        watchdog_restart_instr, // restart pulse from core
  input  wire logic        chip_rst,          // any chip reset, level
  input  wire logic        brownout_rst,      // brown-out reset, async level
  input  wire logic        pin_rst,           // external reset, async level
  output logic             wdt_rst_pulse,     // watchdog system reset pulse
  output logic             wdt_enabled        // watchdog running
);

  wdcf_pkg::wdcf_ctrl_t  ctrl_q;
  wdcf_pkg::wdcf_cause_t cause_q;
  wdcf_pkg::wdcf_reg_t   wr_idx_q;
  logic                  wr_pend_q;
  logic [2:0]            unlock_cnt_q;
  logic [`WDCF_CNT_W-1:0] cnt_q;
  logic                  osc_s1_q;
  logic                  osc_s2_q;
  logic                  osc_s3_q;
  logic                  fuse_s1_q;
  logic                  fuse_s2_q;
  logic                  bor_s1_q;
  logic                  bor_s2_q;
  logic                  pin_s1_q;
  logic                  pin_s2_q;
  logic                  addr_ph;
  logic                  wr_ctrl;
  logic                  wr_cause;
  logic                  open_req;
  logic                  unlock_open;
  logic                  locked;
  logic                  wd_on;
  logic                  tick;
  logic                  expire;
  logic [`WDCF_CNT_W-1:0] limit;
  logic [2:0]            sel_wr;
  logic                  clr_wdog;
  logic                  clr_bor;
  logic                  clr_pin;
  logic                  clr_por;
  logic [2:0]            win_age_q;

  function automatic wdcf_pkg::wdcf_reg_t reg_decode(input logic [31:0] addr);
    if (addr == `WDCF_ADDR_CAUSE) begin
      return wdcf_pkg::WDCF_REG_CAUSE;
    end else if (addr == `WDCF_ADDR_CTRL) begin
      return wdcf_pkg::WDCF_REG_CTRL;
    end else begin
      return wdcf_pkg::WDCF_REG_NONE;
    end
  endfunction

  // each code doubles the base count
  function automatic logic [`WDCF_CNT_W-1:0] timeout_limit(input logic [2:0] sel);
    return `WDCF_CNT_W'(BASE_TIMEOUT) << sel;
  endfunction

  // pin inputs: the first stage feeds only the second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
      bor_s1_q  <= 1'b0;
      bor_s2_q  <= 1'b0;
      pin_s1_q  <= 1'b0;
      pin_s2_q  <= 1'b0;
    end else if (clk_en) begin
      osc_s1_q  <= wdt_osc;
      osc_s2_q  <= osc_s1_q;
      osc_s3_q  <= osc_s2_q;
      fuse_s1_q <= safety_level_fuse;
      fuse_s2_q <= fuse_s1_q;
      bor_s1_q  <= brownout_rst;
      bor_s2_q  <= bor_s1_q;
      pin_s1_q  <= pin_rst;
      pin_s2_q  <= pin_s1_q;
    end
  end

  // oscillator is far slower than the system clock, so edge sampling is safe
  assign tick        = osc_s2_q & ~osc_s3_q;
  assign locked      = fuse_s2_q;
  assign wd_on       = ctrl_q.watchdog_on_bit | locked;
  assign unlock_open = (unlock_cnt_q != 3'h0);
  assign limit       = timeout_limit(ctrl_q.timeout_select);
  // >= so a shortened select cannot skip past the limit
  assign expire      = wd_on & tick & (cnt_q >= limit - `WDCF_CNT_W'(1));

  // bus slave: zero wait states, always okay
  assign addr_ph  = hsel & htrans[1] & hready;
  assign wr_ctrl  = wr_pend_q & (wr_idx_q == wdcf_pkg::WDCF_REG_CTRL);
  assign wr_cause = wr_pend_q & (wr_idx_q == wdcf_pkg::WDCF_REG_CAUSE);
  assign open_req = wr_ctrl & hwdata[`WDCF_UNLOCK_BIT] & hwdata[`WDCF_ON_BIT];
  assign sel_wr   = hwdata[`WDCF_SEL_MSB:`WDCF_SEL_LSB];
  // a cause bit clears only when its written bit is zero; ones leave it alone
  assign clr_wdog = wr_cause & ~hwdata[`WDCF_WDOG_FLAG_BIT];
  assign clr_bor  = wr_cause & ~hwdata[`WDCF_BOR_FLAG_BIT];
  assign clr_pin  = wr_cause & ~hwdata[`WDCF_PIN_FLAG_BIT];
  assign clr_por  = wr_cause & ~hwdata[`WDCF_POR_BIT];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= wdcf_pkg::WDCF_REG_NONE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      wr_pend_q <= addr_ph & hwrite;
      wr_idx_q  <= reg_decode(haddr);
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data is caught at the address edge and stands through the data phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (clk_en && addr_ph && !hwrite) begin
      if (reg_decode(haddr) == wdcf_pkg::WDCF_REG_CAUSE) begin
        hrdata <= {28'h0000000, cause_q};
      end else if (reg_decode(haddr) == wdcf_pkg::WDCF_REG_CTRL) begin
        hrdata <= {27'h0000000, ctrl_q.watchdog_change_unlock, wd_on,
                   ctrl_q.timeout_select};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  // change window: counts system clocks, not bus cycles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      unlock_cnt_q <= 3'h0;
    end else if (clk_en) begin
      if (chip_rst) begin
        unlock_cnt_q <= 3'h0;
      end else if (open_req) begin
        unlock_cnt_q <= `WDCF_UNLOCK_CYCLES;
      end else if (unlock_open) begin
        unlock_cnt_q <= unlock_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `WDCF_CTRL_RST;
    end else if (clk_en) begin
      if (chip_rst) begin
        ctrl_q <= `WDCF_CTRL_RST;
      end else begin
        ctrl_q.watchdog_change_unlock <= open_req | (unlock_cnt_q > 3'h1);
        if (wr_ctrl && hwdata[`WDCF_ON_BIT]) begin
          ctrl_q.watchdog_on_bit <= 1'b1;
        end else if (wr_ctrl && unlock_open && !locked) begin
          ctrl_q.watchdog_on_bit <= 1'b0;
        end
        // when locked the enable value written is irrelevant
        if (wr_ctrl && unlock_open) begin
          ctrl_q.timeout_select <= sel_wr;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (chip_rst || !wd_on || expire) begin
        cnt_q <= '0;
      end else if (watchdog_restart_instr) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= cnt_q + `WDCF_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wdt_rst_pulse <= 1'b0;
      wdt_enabled   <= 1'b0;
    end else if (clk_en) begin
      wdt_rst_pulse <= expire;
      wdt_enabled   <= wd_on;
    end
  end

  // nrst is the power-on reset; hardware set wins over a software clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cause_q <= `WDCF_CAUSE_RST;
    end else if (clk_en) begin
      cause_q.watchdog_cause_flag <= expire |
        (cause_q.watchdog_cause_flag & ~clr_wdog);
      cause_q.brownout_cause_flag <= bor_s2_q |
        (cause_q.brownout_cause_flag & ~clr_bor);
      cause_q.pin_reset_cause_flag <= pin_s2_q |
        (cause_q.pin_reset_cause_flag & ~clr_pin);
      cause_q.poweron_cause_flag <= cause_q.poweron_cause_flag & ~clr_por;
    end
  end

  // age of the newest change window, saturating; only the assertions read it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      win_age_q <= 3'h7;
    end else if (clk_en) begin
      if (open_req) begin
        win_age_q <= 3'h0;
      end else if (win_age_q != 3'h7) begin
        win_age_q <= win_age_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_open;
    clk_en && open_req && !chip_rst;
  endsequence

  sequence s_quiet4;
    (clk_en && !open_req && !chip_rst) [*4];
  endsequence

  AST_PULSE_ONE_CYCLE: assert property (
    (clk_en && wdt_rst_pulse) |=> !wdt_rst_pulse)
    else $error("watchdog reset pulse longer than one cycle");

  AST_EXPIRE_RESETS: assert property (
    (clk_en && expire) |=> (wdt_rst_pulse && cause_q.watchdog_cause_flag && cnt_q == '0))
    else $error("timeout did not raise reset and flag");

  AST_RESTART_CLEARS: assert property (
    (clk_en && watchdog_restart_instr) |=> (cnt_q == '0))
    else $error("restart did not clear counter");

  AST_OFF_CLEARS: assert property (
    (clk_en && (!wd_on || chip_rst)) |=> (cnt_q == '0))
    else $error("counter not cleared while off or in chip reset");

  AST_WINDOW_OPENS: assert property (
    s_open |=> (unlock_open && ctrl_q.watchdog_change_unlock))
    else $error("change window did not open");

  AST_WINDOW_CLOSES: assert property (
    s_open ##1 s_quiet4 |=> (!unlock_open && !ctrl_q.watchdog_change_unlock))
    else $error("change window not closed after four cycles");

  AST_SEL_NEEDS_WINDOW: assert property (
    (clk_en && !unlock_open && !chip_rst) |=> $stable(ctrl_q.timeout_select))
    else $error("timeout select changed outside the window");

  AST_OFF_NEEDS_WINDOW: assert property (
    (clk_en && wd_on && !unlock_open && !chip_rst) |=> wd_on)
    else $error("watchdog disabled without change window");

  AST_ENABLE_FREE: assert property (
    (clk_en && wr_ctrl && hwdata[`WDCF_ON_BIT] && !chip_rst) |=> ##1 wdt_enabled)
    else $error("write of enable one did not start watchdog");

  AST_LOCK_READS_ON: assert property (
    (clk_en && locked && addr_ph && !hwrite &&
     reg_decode(haddr) == wdcf_pkg::WDCF_REG_CTRL) |=> hrdata[`WDCF_ON_BIT])
    else $error("locked watchdog read enable as zero");

  AST_RESERVED_ZERO: assert property (
    (clk_en && addr_ph && !hwrite) |=> (hrdata[31:5] == 27'h0000000))
    else $error("reserved bits read nonzero");

  AST_POR_STICKY: assert property (
    (clk_en && cause_q.poweron_cause_flag && !wr_cause) |=> cause_q.poweron_cause_flag)
    else $error("power-on flag lost without software clear");

  AST_PIN_SET_WINS: assert property (
    (clk_en && pin_s2_q) |=> cause_q.pin_reset_cause_flag)
    else $error("pin reset flag not set");

  // bus writes: control writes split by whether they land inside the change window, then cause writes
  sequence s_open_write;
    clk_en && wr_ctrl && unlock_open && !chip_rst;
  endsequence

  sequence s_shut_write;
    clk_en && wr_ctrl && !unlock_open && !chip_rst;
  endsequence

  sequence s_cause_write;
    clk_en && wr_cause;
  endsequence

  AST_SEL_TAKEN_IN_WINDOW: assert property (
    s_open_write |=> (ctrl_q.timeout_select == $past(sel_wr)))
    else $error("timeout select not taken inside the window");

  AST_DISABLE_IN_WINDOW: assert property (
    s_open_write ##0 (!locked && !hwdata[`WDCF_ON_BIT]) |=> !ctrl_q.watchdog_on_bit)
    else $error("enable zero inside the window did not disable");

  AST_SHUT_WRITE_ENABLES: assert property (
    s_shut_write ##0 hwdata[`WDCF_ON_BIT] |=> ctrl_q.watchdog_on_bit)
    else $error("enable one outside the window was lost");

  AST_LOCKED_STAYS_ON: assert property (
    (clk_en && locked) |=> wdt_enabled)
    else $error("locked watchdog reported as stopped");

  AST_STOPPED_REPORTED: assert property (
    (clk_en && !wd_on) |=> !wdt_enabled)
    else $error("stopped watchdog reported as running");

  AST_CTRL_CLEARED: assert property (
    (clk_en && chip_rst) |=> (ctrl_q == `WDCF_CTRL_RST && !unlock_open))
    else $error("chip reset did not clear control and window");

  AST_WINDOW_NEEDS_OPEN: assert property (
    (clk_en && !unlock_open && !open_req) |=> !unlock_open)
    else $error("change window opened without an opening write");

  AST_WINDOW_BOUNDED: assert property (
    (clk_en && ctrl_q.watchdog_change_unlock) |-> (win_age_q < `WDCF_UNLOCK_CYCLES))
    else $error("change enable stayed set past four cycles");

  AST_COUNT_ADVANCES: assert property (
    (clk_en && wd_on && tick && !expire && !watchdog_restart_instr && !chip_rst) |=>
      (cnt_q == $past(cnt_q) + `WDCF_CNT_W'(1)))
    else $error("counter did not advance on an oscillator tick");

  AST_PULSE_NEEDS_EXPIRE: assert property (
    (clk_en && !expire) |=> !wdt_rst_pulse)
    else $error("reset pulse without a timeout");

  AST_WDOG_FLAG_CLEARS: assert property (
    s_cause_write ##0 (clr_wdog && !expire) |=> !cause_q.watchdog_cause_flag)
    else $error("watchdog flag not cleared by zero write");

  AST_BOR_SET_WINS: assert property (
    (clk_en && bor_s2_q) |=> cause_q.brownout_cause_flag)
    else $error("brown-out flag not set");

  AST_BOR_FLAG_CLEARS: assert property (
    s_cause_write ##0 (clr_bor && !bor_s2_q) |=> !cause_q.brownout_cause_flag)
    else $error("brown-out flag not cleared by zero write");

  AST_PIN_FLAG_CLEARS: assert property (
    s_cause_write ##0 (clr_pin && !pin_s2_q) |=> !cause_q.pin_reset_cause_flag)
    else $error("pin reset flag not cleared by zero write");

  AST_POR_CLEARS: assert property (
    s_cause_write ##0 clr_por |=> !cause_q.poweron_cause_flag)
    else $error("power-on flag not cleared by zero write");

endmodule

// ==== wdcf_core_model.sv ====
`timescale 1ns/1ps
module wdcf_core_model (
  input  wire logic clock,        // system clock
  input  wire logic kick_req,     // bench asks for one restart
  output logic      wdt_osc,      // watchdog oscillator
  output logic      restart_pulse // one-cycle restart instruction
);
  logic kick_q = 1'b0;
  // free running, not derived from clock; restarts land at any phase of it
  initial begin
    wdt_osc = 1'b0;
    forever #500 wdt_osc = ~wdt_osc;
  end
  always @(posedge clock) begin
    kick_q <= kick_req;
    restart_pulse <= kick_req & ~kick_q;
  end
endmodule

// ==== watchdog_with_reset_cause_flags_bench.sv ====
`timescale 1ns/1ps
`include "wdcf_defines.svh"
module watchdog_with_reset_cause_flags_bench;
  localparam logic [31:0] CAU = `WDCF_ADDR_CAUSE;
  localparam logic [31:0] CTL = `WDCF_ADDR_CTRL;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hready, hresp, wdt_osc, restart, pulse, enabled;
  logic [31:0] hrdata;
  logic        kick = 1'b0, fuse = 1'b0, chip_rst = 1'b0, brown = 1'b0, pin = 1'b0;
  int          bad_count = 0;
  int          checked = 0;

  // short base count keeps the select 0 and 1 timeouts within a few thousand cycles
  wdcf_watchdog #(.BASE_TIMEOUT(16)) DUT (
    .clock(clock), .nrst(nrst), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .wdt_osc(wdt_osc),
    .safety_level_fuse(fuse), .watchdog_restart_instr(restart), .chip_rst(chip_rst),
    .brownout_rst(brown), .pin_rst(pin), .wdt_rst_pulse(pulse), .wdt_enabled(enabled));
  wdcf_core_model core (
    .clock(clock), .kick_req(kick), .wdt_osc(wdt_osc), .restart_pulse(restart));

  always #5 clock = ~clock;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic edge_ready;
    int n;
    n = 0;
    @(posedge clock);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        final_report;
      end
      @(posedge clock);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    edge_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready;
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, {24'h0, e});
  endtask

  // pulse is sampled mid-cycle, after the edge's own updates have landed
  task automatic expire(input int lo, input int hi);
    int n;
    n = 0;
    @(negedge clock);
    while (pulse !== 1'b1 && n <= hi) begin
      n++;
      @(negedge clock);
    end
    check({31'h0, n >= lo && n <= hi}, 32'h1);
    @(negedge clock);
    check({31'h0, pulse}, 32'h0);
    @(posedge clock);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clock);
      if (pulse !== 1'b0) check({31'h0, pulse}, 32'h0);
    end
    @(posedge clock);
  endtask

  // the block never resets itself, so the system reset is played here
  task automatic sys_reset;
    chip_rst <= 1'b1;
    @(posedge clock);
    chip_rst <= 1'b0;
  endtask

  task automatic t_control;
    rd(CAU, 8'h01);
    rd(CTL, 8'h00);
    check({31'h0, enabled}, 32'h0);
    wr(CTL, 8'hef);
    rd(CTL, 8'h08);
    wr(CTL, 8'h00);
    rd(CTL, 8'h08);
    wr(CTL, 8'h18);
    rd(CTL, 8'h18);
    wr(CTL, 8'h01);
    rd(CTL, 8'h01);
    check({31'h0, enabled}, 32'h0);
    wr(CTL, 8'h0e);
    rd(CTL, 8'h09);
  endtask

  task automatic t_timeout;
    expire(3080, 3220);
    rd(CAU, 8'h09);
    sys_reset;
    rd(CTL, 8'h00);
    wr(CTL, 8'h08);
    repeat (6) begin
      kick <= 1'b1;
      @(posedge clock);
      kick <= 1'b0;
      quiet(1000);
    end
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    expire(1490, 1620);
    sys_reset;
  endtask

  task automatic t_flags;
    rd(CAU, 8'h09);
    wr(CAU, 8'hf0);
    rd(CAU, 8'h00);
    brown <= 1'b1;
    pin <= 1'b1;
    repeat (5) @(posedge clock);
    brown <= 1'b0;
    pin <= 1'b0;
    repeat (4) @(posedge clock);
    rd(CAU, 8'h06);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd(CAU, 8'h01);
  endtask

  task automatic t_locked;
    fuse <= 1'b1;
    repeat (4) @(posedge clock);
    check({31'h0, enabled}, 32'h1);
    wr(CTL, 8'h00);
    rd(CTL, 8'h08);
    wr(CTL, 8'h18);
    wr(CTL, 8'h03);
    rd(CTL, 8'h1b);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_control;
    t_timeout;
    t_flags;
    t_locked;
    final_report;
  end
endmodule
